// >>> logic/far_cfg.svh
`ifndef FAR_CFG_SVH
`define FAR_CFG_SVH
// Register byte offsets
`define FAR_ADDR_CTRL 4'h0
`define FAR_ADDR_RETRY0 4'h4
`define FAR_ADDR_RETRY1 4'h8
`define FAR_ADDR_STATUS 4'hc
// Retry configuration field positions
`define FAR_RETRY_SEL_BIT 0
`define FAR_RETRY_UNLIM_BIT 1
`define FAR_RETRY_PER_LO 2
`define FAR_RETRY_PER_HI 3
// Control register field positions
`define FAR_CTRL_SUPFAIL_EN_BIT 0
`define FAR_CTRL_NORMAL_BIT 1
`define FAR_CTRL_DELATCH0_BIT 2
`define FAR_CTRL_DELATCH1_BIT 3
// Status register field positions
`define FAR_STAT_EXH0_BIT 4
`define FAR_STAT_EXH1_BIT 5
`define FAR_STAT_POR_BIT 6
`define FAR_STAT_FAILSAFE_BIT 7
// Reset values
`define FAR_RETRY_RESET 4'h0
`define FAR_CTRL_RESET 2'h0
// Retry periods, microseconds, and clock rate
`define FAR_CLK_MHZ 40
`define FAR_T_RETRY0_US 2500
`define FAR_T_RETRY1_US 5000
`define FAR_T_RETRY2_US 10000
`define FAR_T_RETRY3_US 20000
`define FAR_CYC(us) ((us) * `FAR_CLK_MHZ)
`define FAR_RETRY_MAX 4'hf
// Cycles after reset until the synchronised pins are trustworthy for edge detection
`define FAR_FILL_CYCLES 3'h5
`endif

// >>> logic/far_pkg.sv
package far_pkg;
  typedef enum logic [3:0] {
    FAR_IDLE  = 4'h1,
    FAR_WAIT  = 4'h2,
    FAR_RETRY = 4'h4,
    FAR_LATCH = 4'h8
  } far_state_type;
  typedef logic [3:0] far_count_type;
endpackage

// >>> logic/far_top.sv
`include "far_cfg.svh"
// How it works
// - Only overcurrent, short, overtemperature and undervoltage can start a retry.
// - Undervoltage and overtemperature retries begin only after the cause clears.
// - Retry condition is OR of channel faults and shared undervoltage.
// - Retry enabled when select bit equals load profile setting.
// - With retry disabled, a latchable fault latches the channel off at once.
// - Retry starts when fault control and retry condition are both true.
// - Channel turns back on after the retry period selected by two bits.
// - Fault clearing resumes normal operation, keeps counter and fault bit.
// - Unlimited retries never latch the channel off.
// - Limited mode retries while the 4-bit counter stays within 15.
// - After 15 retries a per-channel exhausted bit is set in status.
// - Once exhausted one more try; persistent fault latches off, fault pin low.
// - Host delatch turns channel on without clearing the retry counter.
// - Retry counter readable only in Normal mode.
// - Any latchable fault forces fastest turn-off ignoring slew setting.
// - Logic supply loss with enable set enters fail-safe, resets registers.
// - Without the enable, supply loss keeps serial control.
// - Without logic supply, faults still reach the fault pin.
// - Power-on flag set when one supply rises while the other stays low.
// - Power-on flag also set on wake transition with a supply already up.
// - No power-on reset when power recovers with logic supply always up.
// - Serial access stays available during power undervoltage.
// - Counter cleared on fail-safe, sleep exit, reset, unlimited or disable.
// - Lighting profile clears the overcurrent duration counter at each retry.
module far_top (
  input wire logic CLOCK_IN, // 40 MHz clock
  input wire logic RST_IN, // Asynchronous reset, active high
  input wire logic [3:0] WB_ADR_IN, // Wishbone byte address
  input wire logic [31:0] WB_DAT_IN, // Wishbone write data
  output logic [31:0] WB_DAT_OUT, // Wishbone read data
  input wire logic WB_WE_IN, // Write enable
  input wire logic [3:0] WB_SEL_IN, // Byte selects
  input wire logic WB_CYC_IN, // Cycle
  input wire logic WB_STB_IN, // Strobe
  output logic WB_ACK_OUT, // Acknowledge
  input wire logic [1:0] OVERCURRENT_FAULT_IN, // Per-channel overcurrent
  input wire logic [1:0] SHORT_CIRCUIT_FAULT_IN, // Per-channel severe short
  input wire logic [1:0] OVERTEMP_FAULT_IN, // Per-channel overtemperature
  input wire logic UNDERVOLTAGE_FAULT_IN, // Shared power undervoltage
  input wire logic [1:0] FAULT_CONTROL_IN, // Per-channel fault control
  input wire logic [1:0] LOAD_PROFILE_SELECT_IN, // 0 lighting, 1 motor
  input wire logic [1:0] DIRECT_IN, // Direct channel inputs
  input wire logic [1:0] CHANNEL_REQ_IN, // Serial-controlled on request
  input wire logic LOGIC_SUPPLY_OK_IN, // Logic supply above threshold
  input wire logic POWER_SUPPLY_OK_IN, // Power supply above threshold
  input wire logic WAKE_RESET_PIN_IN, // Wake/reset pin
  output logic [1:0] CHANNEL_ON_OUT, // Channel gate enable
  output logic [1:0] FAST_OFF_OUT, // Fastest turn-off request
  output logic [1:0] DURATION_CLEAR_OUT, // Overcurrent duration counter clear
  output logic FAULT_FLAG_N_OUT, // Fault pin, low on fault
  output logic SERIAL_READY_OUT // Serial readout available
);
  // ----------------------------------------------------------------
  // Synchronisers and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] far_period(input logic [1:0] sel);
    unique case (sel)
      2'h0: far_period = 32'(`FAR_CYC(`FAR_T_RETRY0_US));
      2'h1: far_period = 32'(`FAR_CYC(`FAR_T_RETRY1_US));
      2'h2: far_period = 32'(`FAR_CYC(`FAR_T_RETRY2_US));
      default: far_period = 32'(`FAR_CYC(`FAR_T_RETRY3_US));
    endcase
  endfunction

  logic [10:0] sync_a_reg, sync_b_reg, sync_c_reg, clean_reg;
  logic [10:0] raw_in;
  assign raw_in = {WAKE_RESET_PIN_IN, POWER_SUPPLY_OK_IN, LOGIC_SUPPLY_OK_IN, DIRECT_IN,
    OVERTEMP_FAULT_IN, SHORT_CIRCUIT_FAULT_IN, OVERCURRENT_FAULT_IN};

  // Three stages; a change counts once the last two agree, filtering one-cycle glitches
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync_a_reg <= 11'h000;
      sync_b_reg <= 11'h000;
      sync_c_reg <= 11'h000;
      clean_reg <= 11'h000;
    end else begin
      sync_a_reg <= raw_in;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
      clean_reg <= (sync_b_reg & sync_c_reg) | (clean_reg & (sync_b_reg | sync_c_reg));
    end
  end

  logic [1:0] oc, sc, ot, din;
  logic vdd_ok, vpwr_ok, wake, uv_sync, uv_a_reg, uv_b_reg, uv_c_reg, uv_reg;
  assign oc = clean_reg[1:0];
  assign sc = clean_reg[3:2];
  assign ot = clean_reg[5:4];
  assign din = clean_reg[7:6];
  assign vdd_ok = clean_reg[8];
  assign vpwr_ok = clean_reg[9];
  assign wake = clean_reg[10] | (|din);

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      uv_a_reg <= 1'b0;
      uv_b_reg <= 1'b0;
      uv_c_reg <= 1'b0;
      uv_reg <= 1'b0;
    end else begin
      uv_a_reg <= UNDERVOLTAGE_FAULT_IN;
      uv_b_reg <= uv_a_reg;
      uv_c_reg <= uv_b_reg;
      uv_reg <= (uv_b_reg == uv_c_reg) ? uv_b_reg : uv_reg;
    end
  end
  assign uv_sync = uv_reg;

  // ----------------------------------------------------------------
  // Supply monitor, power-on flag and fail-safe
  // ----------------------------------------------------------------
  logic vdd_d_reg, vpwr_d_reg, wake_d_reg, por_flag_reg, failsafe_reg;
  logic por_event, failsafe_entry, sleep_exit, soft_reset;
  logic [2:0] fill_reg;
  logic primed;
  // Edge detectors stay masked until the synchronisers have filled after reset;
  // otherwise pins settling from the reset value would look like supply or wake edges
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fill_reg <= 3'h0;
    end else if (fill_reg != `FAR_FILL_CYCLES) begin
      fill_reg <= fill_reg + 3'h1;
    end
  end
  assign primed = (fill_reg == `FAR_FILL_CYCLES);
  // One supply rising while the other stays low is a true power-on
  // Power recovering with logic supply held up is not
  // Wake edge with a supply already up also flags power-on
  assign por_event = primed & ((vpwr_ok & ~vpwr_d_reg & ~vdd_ok & ~vdd_d_reg) |
    (vdd_ok & ~vdd_d_reg & ~vpwr_ok & ~vpwr_d_reg) |
    (wake & ~wake_d_reg & ((vpwr_ok & vpwr_d_reg) | (vdd_ok & vdd_d_reg))));
  assign sleep_exit = primed & wake & ~wake_d_reg;
  logic supfail_en_reg;
  // Fail-safe only when software armed it before the supply dropped
  assign failsafe_entry = primed & ~vdd_ok & vdd_d_reg & supfail_en_reg & ~failsafe_reg;
  assign soft_reset = failsafe_entry | por_event;

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      vdd_d_reg <= 1'b0;
      vpwr_d_reg <= 1'b0;
      wake_d_reg <= 1'b0;
    end else begin
      vdd_d_reg <= vdd_ok;
      vpwr_d_reg <= vpwr_ok;
      wake_d_reg <= wake;
    end
  end

  // Fail-safe holds until the logic supply returns
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      failsafe_reg <= 1'b0;
    end else if (failsafe_entry) begin
      failsafe_reg <= 1'b1;
    end else if (vdd_ok) begin
      failsafe_reg <= 1'b0;
    end
  end

  // Serial readout needs the logic supply; power undervoltage does not block it
  assign SERIAL_READY_OUT = vdd_ok;

  // ----------------------------------------------------------------
  // Wishbone registers
  // ----------------------------------------------------------------
  logic [3:0] retry_cfg_reg [2];
  logic normal_reg, ack_reg, wr, rd_status;
  logic [1:0] delatch_pulse, exh_reg, latched;
  far_pkg::far_count_type cnt_reg [2];
  assign wr = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ~ack_reg & WB_SEL_IN[0];
  assign rd_status = WB_CYC_IN & WB_STB_IN & ~WB_WE_IN & ~ack_reg &
    (WB_ADR_IN == `FAR_ADDR_STATUS);
  assign delatch_pulse = (wr && WB_ADR_IN == `FAR_ADDR_CTRL) ?
    {WB_DAT_IN[`FAR_CTRL_DELATCH1_BIT], WB_DAT_IN[`FAR_CTRL_DELATCH0_BIT]} : 2'h0;

  // Control writes; control and retry configuration registers return to reset on fail-safe or power-on
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      supfail_en_reg <= 1'b0;
      normal_reg <= 1'b0;
      retry_cfg_reg[0] <= `FAR_RETRY_RESET;
      retry_cfg_reg[1] <= `FAR_RETRY_RESET;
    end else if (soft_reset) begin
      supfail_en_reg <= 1'b0;
      normal_reg <= 1'b0;
      retry_cfg_reg[0] <= `FAR_RETRY_RESET;
      retry_cfg_reg[1] <= `FAR_RETRY_RESET;
    end else if (wr) begin
      if (WB_ADR_IN == `FAR_ADDR_CTRL) begin
        supfail_en_reg <= WB_DAT_IN[`FAR_CTRL_SUPFAIL_EN_BIT];
        normal_reg <= WB_DAT_IN[`FAR_CTRL_NORMAL_BIT];
      end
      if (WB_ADR_IN == `FAR_ADDR_RETRY0) begin
        retry_cfg_reg[0] <= WB_DAT_IN[3:0];
      end
      if (WB_ADR_IN == `FAR_ADDR_RETRY1) begin
        retry_cfg_reg[1] <= WB_DAT_IN[3:0];
      end
    end
  end

  // Power-on flag: set wins over the clear-on-read of status
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      por_flag_reg <= 1'b1;
    end else if (por_event) begin
      por_flag_reg <= 1'b1;
    end else if (rd_status) begin
      por_flag_reg <= 1'b0;
    end
  end

  // Single-cycle ack; unmapped addresses read zero and ignore writes
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ack_reg <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      ack_reg <= WB_CYC_IN & WB_STB_IN & ~ack_reg;
      WB_DAT_OUT <= 32'h0000_0000;
      unique case (WB_ADR_IN)
        `FAR_ADDR_CTRL: WB_DAT_OUT <= {30'h0, normal_reg, supfail_en_reg};
        // Counter shows in the upper nibble only in Normal mode
        `FAR_ADDR_RETRY0: WB_DAT_OUT <= {24'h0, normal_reg ? cnt_reg[0] : 4'h0,
          retry_cfg_reg[0]};
        `FAR_ADDR_RETRY1: WB_DAT_OUT <= {24'h0, normal_reg ? cnt_reg[1] : 4'h0,
          retry_cfg_reg[1]};
        `FAR_ADDR_STATUS: WB_DAT_OUT <= {24'h0, failsafe_reg, por_flag_reg, exh_reg, 2'h0,
          latched};
        default: WB_DAT_OUT <= 32'h0000_0000;
      endcase
    end
  end
  assign WB_ACK_OUT = ack_reg;

  // ----------------------------------------------------------------
  // Per-channel retry machine
  // ----------------------------------------------------------------
  far_pkg::far_state_type st_reg [2];
  logic [31:0] tmr_reg [2];
  logic [1:0] en_d_reg, retry_cond, retry_en, fault_now, dur_clr;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic sel, unlim, cnt_clear, cause_gone, at_max;
    assign sel = retry_cfg_reg[ch][`FAR_RETRY_SEL_BIT];
    assign unlim = retry_cfg_reg[ch][`FAR_RETRY_UNLIM_BIT];
    assign retry_cond[ch] = oc[ch] | sc[ch] | ot[ch] | uv_sync;
    assign retry_en[ch] = (sel == LOAD_PROFILE_SELECT_IN[ch]);
    assign fault_now[ch] = retry_cond[ch];
    // Thermal and supply faults must vanish before the timer runs
    assign cause_gone = ~ot[ch] & ~uv_sync;
    assign at_max = (cnt_reg[ch] == `FAR_RETRY_MAX);
    // Counter clears on fail-safe, wake, power-on, unlimited, or retry disabled
    assign cnt_clear = soft_reset | sleep_exit | unlim | (en_d_reg[ch] & ~retry_en[ch]);

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        en_d_reg[ch] <= 1'b0;
      end else begin
        en_d_reg[ch] <= retry_en[ch];
      end
    end

    // Fault sequencing
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        st_reg[ch] <= far_pkg::FAR_IDLE;
        tmr_reg[ch] <= 32'h0;
        cnt_reg[ch] <= `FAR_RETRY_RESET;
        exh_reg[ch] <= 1'b0;
      end else begin
        if (cnt_clear) begin
          cnt_reg[ch] <= `FAR_RETRY_RESET;
          exh_reg[ch] <= 1'b0;
        end
        unique case (st_reg[ch])
          far_pkg::FAR_IDLE: begin
            // A fault after the spare attempt of an exhausted counter latches at once
            if (fault_now[ch] && FAULT_CONTROL_IN[ch]) begin
              if (retry_en[ch] && (unlim || !exh_reg[ch])) begin
                st_reg[ch] <= far_pkg::FAR_WAIT;
                tmr_reg[ch] <= far_period(retry_cfg_reg[ch][3:2]);
              end else begin
                st_reg[ch] <= far_pkg::FAR_LATCH;
              end
            end
          end
          far_pkg::FAR_WAIT: begin
            if (delatch_pulse[ch]) begin
              st_reg[ch] <= far_pkg::FAR_IDLE;
            end else if (!cause_gone) begin
              tmr_reg[ch] <= far_period(retry_cfg_reg[ch][3:2]);
            end else if (tmr_reg[ch] > 32'h1) begin
              tmr_reg[ch] <= tmr_reg[ch] - 32'h1;
            end else if (!unlim && exh_reg[ch] && fault_now[ch]) begin
              st_reg[ch] <= far_pkg::FAR_LATCH;
            end else begin
              st_reg[ch] <= far_pkg::FAR_RETRY;
              if (!unlim && !cnt_clear) begin
                if (at_max) begin
                  exh_reg[ch] <= 1'b1;
                end else begin
                  cnt_reg[ch] <= cnt_reg[ch] + 4'h1;
                end
              end
            end
          end
          far_pkg::FAR_RETRY: begin
            // One cycle of turn-on; back to normal keeps counter
            st_reg[ch] <= far_pkg::FAR_IDLE;
          end
          far_pkg::FAR_LATCH: begin
            if (delatch_pulse[ch] || (cnt_clear && retry_en[ch] && !soft_reset)) begin
              st_reg[ch] <= far_pkg::FAR_IDLE;
            end
          end
        endcase
      end
    end

    assign latched[ch] = (st_reg[ch] == far_pkg::FAR_LATCH);
    // Lighting clears inrush window at each retry; motor keeps it
    assign dur_clr[ch] = (st_reg[ch] == far_pkg::FAR_RETRY) & ~LOAD_PROFILE_SELECT_IN[ch];
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [1:0] on_next;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // Fail-safe hands control to the direct inputs
      on_next[i] = (failsafe_reg ? din[i] : CHANNEL_REQ_IN[i]) & ~fault_now[i] &
        (st_reg[i] == far_pkg::FAR_IDLE || st_reg[i] == far_pkg::FAR_RETRY);
    end
  end

  // Gate enable, registered so the switch never sees a decode glitch
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CHANNEL_ON_OUT <= 2'h0;
    end else begin
      CHANNEL_ON_OUT <= on_next;
    end
  end

  // Fast turn-off follows the live faults and ignores any slew setting
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      FAST_OFF_OUT <= 2'h0;
    end else begin
      FAST_OFF_OUT <= fault_now;
    end
  end

  // Inrush window clear, one cycle per lighting retry
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      DURATION_CLEAR_OUT <= 2'h0;
    end else begin
      DURATION_CLEAR_OUT <= dur_clr;
    end
  end

  // Pin reports live faults and latch-off even without logic supply
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      FAULT_FLAG_N_OUT <= 1'b1;
    end else begin
      FAULT_FLAG_N_OUT <= ~((|fault_now) | (|latched));
    end
  end
endmodule

// >>> testbench/far_load_model.sv
module far_load_model (
  input wire logic clk_in, // Bench clock
  input wire logic [1:0] channel_on_in, // Gate enables from the switch
  input wire logic [1:0] short_in, // Load shorted, per channel
  output logic [1:0] overcurrent_out // Overcurrent seen by the sense path
);
  timeunit 1ns;
  timeprecision 100ps;
  // Current flows only while the gate is on, so turning off clears the fault
  always_ff @(posedge clk_in) begin
    overcurrent_out <= channel_on_in & short_in;
  end
endmodule

// >>> testbench/far_top_monitor.sv
module far_top_monitor (
  input wire logic CLOCK_IN, // Clock
  input wire logic RST_IN, // Reset
  input wire logic WB_CYC_IN, // Cycle
  input wire logic WB_STB_IN, // Strobe
  input wire logic WB_ACK_OUT, // Acknowledge
  input wire logic [1:0] OVERCURRENT_FAULT_IN, // Overcurrent
  input wire logic [1:0] OVERTEMP_FAULT_IN, // Overtemperature
  input wire logic LOGIC_SUPPLY_OK_IN, // Logic supply good
  input wire logic [1:0] LOAD_PROFILE_SELECT_IN, // Load profile
  input wire logic [1:0] CHANNEL_ON_OUT, // Gate enables
  input wire logic [1:0] FAST_OFF_OUT, // Fast turn-off
  input wire logic [1:0] DURATION_CLEAR_OUT, // Duration clear
  input wire logic FAULT_FLAG_N_OUT, // Fault pin
  input wire logic SERIAL_READY_OUT // Serial readout available
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);
  // Faults pass a 3-flop synchroniser, a filter flop and the output flop, so six held samples are just enough for fast turn-off
  AST_ACK_NEXT: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("bus request not answered in one cycle");
  AST_ACK_PULSE: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("acknowledge longer than one cycle");
  AST_FAST_OFF: assert property ((OVERCURRENT_FAULT_IN[0] || OVERTEMP_FAULT_IN[0]) [*6]
    |-> FAST_OFF_OUT[0]) else $error("fault without fast turn-off");
  AST_OFF_GATE: assert property ($rose(FAST_OFF_OUT[0]) |-> ##[0:2] !CHANNEL_ON_OUT[0])
    else $error("channel left on after fast turn-off");
  AST_FLAG_LOW: assert property ($rose(FAST_OFF_OUT[0]) |-> ##[0:2] !FAULT_FLAG_N_OUT)
    else $error("fault pin not low on fault");
  AST_READY_DROP: assert property ((!LOGIC_SUPPLY_OK_IN) [*6] |-> !SERIAL_READY_OUT)
    else $error("readout still available without logic supply");
  AST_DUR_CLR: assert property (DURATION_CLEAR_OUT[0]
    |-> !LOAD_PROFILE_SELECT_IN[0] ##1 !DURATION_CLEAR_OUT[0])
    else $error("duration clear outside lighting or too long");
  AST_OT_HOLD: assert property (OVERTEMP_FAULT_IN[0] [*6] |-> !$rose(CHANNEL_ON_OUT[0]))
    else $error("channel turned on while overtemperature present");
endmodule

// >>> testbench/far_top_bench.sv
module far_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, we, cyc, stb, uv, vdd_ok, pwr_ok, wake;
  logic [3:0] adr, sel;
  logic [31:0] wdat;
  logic [1:0] sc, ot, fc, prof, dir, req, shrt, per;
  wire [31:0] rdat;
  wire ack, flag_n, ready;
  wire [1:0] oc, ch_on, fast_off, dur_clr;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int bad_count, num_checks, seed, kind;
  logic en;
  // ----------------------------------------
  // Design and load
  // ----------------------------------------
  far_top i_dut (.CLOCK_IN(clk), .RST_IN(rst), .WB_ADR_IN(adr), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_WE_IN(we), .WB_SEL_IN(sel), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_ACK_OUT(ack), .OVERCURRENT_FAULT_IN(oc), .SHORT_CIRCUIT_FAULT_IN(sc),
    .OVERTEMP_FAULT_IN(ot), .UNDERVOLTAGE_FAULT_IN(uv), .FAULT_CONTROL_IN(fc),
    .LOAD_PROFILE_SELECT_IN(prof), .DIRECT_IN(dir), .CHANNEL_REQ_IN(req),
    .LOGIC_SUPPLY_OK_IN(vdd_ok), .POWER_SUPPLY_OK_IN(pwr_ok), .WAKE_RESET_PIN_IN(wake),
    .CHANNEL_ON_OUT(ch_on), .FAST_OFF_OUT(fast_off), .DURATION_CLEAR_OUT(dur_clr),
    .FAULT_FLAG_N_OUT(flag_n), .SERIAL_READY_OUT(ready));
  far_load_model i_load (.clk_in(clk), .channel_on_in(ch_on), .short_in(shrt),
    .overcurrent_out(oc));
  // Clock
  always #12.5 clk = ~clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task test_done;
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A read with an empty mask only clears read-sensitive flags
  task wb(input logic [3:0] a, input logic w, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m);
    int n;
    if (!w && m != 32'h0) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      test_done;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // Read data is valid only in the acknowledge cycle
  always @(posedge clk) begin
    if (ack === 1'b1 && !we && exp_q.size() > 0) begin
      chk(rdat & msk_q[0], exp_q[0]);
      exp_q.delete(0);
      msk_q.delete(0);
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    clk = 1'b0; rst = 1'b1; we = 1'b0; cyc = 1'b0; stb = 1'b0; adr = 4'h0; sel = 4'h0;
    wdat = 32'h0; sc = 2'b00; ot = 2'b00; fc = 2'b11; prof = 2'b00; dir = 2'b00;
    req = 2'b11; shrt = 2'b00; uv = 1'b0; vdd_ok = 1'b1; pwr_ok = 1'b1; wake = 1'b1;
    bad_count = 0; num_checks = 0; seed = 32'h1280a33b;
    // Every profile and select pairing, with a random latchable fault kind
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 2; s++) begin
        kind = {$random(seed)} % 3;
        per = 2'($random(seed));
        prof <= {p[0], p[0]};
        do_reset;
        wr_cfg(per, s[0]);
        repeat (8) @(posedge clk);
        if (kind == 0) shrt <= 2'b01;
        else if (kind == 1) sc <= 2'b01;
        else ot <= 2'b01;
        repeat (20) @(posedge clk);
        chk({31'h0, fast_off[0]}, {31'h0, kind != 0});
        chk({31'h0, dur_clr[0]}, 32'h0);
        shrt <= 2'b00;
        sc <= 2'b00;
        ot <= 2'b00;
        repeat (10) @(posedge clk);
        en = (s == p);
        chk({31'h0, ch_on[0]}, 32'h0);
        chk({31'h0, flag_n}, {31'h0, en});
        wb(4'hc, 1'b0, 32'h0, {24'h0, 7'h20, !en}, 32'hff);
        wb(4'h4, 1'b0, 32'h0, {28'h0, per, 1'b0, s[0]}, 32'hff);
        // Delatch brings the channel back whether it waits or is latched
        wb(4'h0, 1'b1, 32'h6, 32'h0, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, ch_on[0]}, 32'h1);
      end
    end
    // Logic supply loss with and without the fail-safe enable
    for (int e = 0; e < 2; e++) begin
      do_reset;
      wb(4'hc, 1'b0, 32'h0, 32'h40, 32'hff);
      wb(4'h0, 1'b1, e | 2, 32'h0, 32'h0);
      vdd_ok <= 1'b0;
      repeat (8) @(posedge clk);
      chk({31'h0, ready}, 32'h0);
      // Fail-safe hands channel 1 to its direct input, which is held low
      chk({31'h0, ch_on[1]}, {31'h0, e == 0});
      ot <= 2'b01;
      repeat (10) @(posedge clk);
      chk({31'h0, flag_n}, 32'h0);
      ot <= 2'b00;
      vdd_ok <= 1'b1;
      repeat (12) @(posedge clk);
      // Fail-safe has ended once the logic supply is back; only armed loss wiped control
      wb(4'hc, 1'b0, 32'h0, 32'h0, 32'h80);
      wb(4'h0, 1'b0, 32'h0, (1 - e) << 1, 32'h03);
    end
    // Power recovery alone must not raise the power-on flag, a wake edge must
    wb(4'hc, 1'b0, 32'h0, 32'h0, 32'h0);
    pwr_ok <= 1'b0;
    repeat (10) @(posedge clk);
    pwr_ok <= 1'b1;
    repeat (10) @(posedge clk);
    wb(4'hc, 1'b0, 32'h0, 32'h0, 32'h40);
    wake <= 1'b0;
    repeat (10) @(posedge clk);
    wake <= 1'b1;
    repeat (10) @(posedge clk);
    wb(4'hc, 1'b0, 32'h0, 32'h40, 32'h40);
    wb(4'h2, 1'b0, 32'h0, 32'h0, 32'hffffffff);
    repeat (4) @(posedge clk);
    test_done;
  end
  task wr_cfg(input logic [1:0] p, input logic s);
    wb(4'h4, 1'b1, {28'h0, p, 1'b0, s}, 32'h0, 32'h0);
    wb(4'h0, 1'b1, 32'h2, 32'h0, 32'h0);
  endtask
endmodule
bind far_top far_top_monitor i_mon (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
  .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT),
  .OVERCURRENT_FAULT_IN(OVERCURRENT_FAULT_IN), .OVERTEMP_FAULT_IN(OVERTEMP_FAULT_IN),
  .LOGIC_SUPPLY_OK_IN(LOGIC_SUPPLY_OK_IN), .LOAD_PROFILE_SELECT_IN(LOAD_PROFILE_SELECT_IN),
  .CHANNEL_ON_OUT(CHANNEL_ON_OUT), .FAST_OFF_OUT(FAST_OFF_OUT),
  .DURATION_CLEAR_OUT(DURATION_CLEAR_OUT), .FAULT_FLAG_N_OUT(FAULT_FLAG_N_OUT),
  .SERIAL_READY_OUT(SERIAL_READY_OUT));
